/* shared/fgw_map.svh */
// Register map, field positions, reset values and timing counts of the watchdog.
// Assumes a 200 MHz core clock and a register port with small word addresses.
`ifndef FGW_MAP_SVH
`define FGW_MAP_SVH

// Register addresses on the plain register port
`define FGW_ADDR_W 4
`define FGW_CTRL_ADDR 4'h0
`define FGW_STAT_ADDR 4'h1

// Control register fields
`define FGW_BIT_UNLOCK 4
`define FGW_BIT_ENABLE 3
`define FGW_SEL_HI 2
`define FGW_SEL_LO 0
`define FGW_SEL_RESET 3'h0

// Reset status register fields
`define FGW_BIT_WDFLAG 3

// Change window length in core clock cycles
`define FGW_UNLOCK_CYCLES 3'h4

// Clock rates in kHz; the watchdog tick is derived from the core clock
`define FGW_CLK_KHZ 200000
`define FGW_OSC_KHZ 1000
`define FGW_OSC_DIV (`FGW_CLK_KHZ / `FGW_OSC_KHZ)

// Shortest time-out in oscillator ticks
`define FGW_BASE_TICKS 16384

`endif

/* shared/fgw_pkg.sv */
// Types shared by the watchdog design files.
// Assumes fgw_map.svh supplies the numeric constants.
package fgw_pkg;

  typedef enum logic [1:0] {
    FGW_ST_LOAD = 2'h0,
    FGW_ST_RUN = 2'h1,
    FGW_ST_FIRE = 2'h3
  } fgw_state_e;

  typedef enum logic [1:0] {
    FGW_LVL0 = 2'h0,
    FGW_LVL1 = 2'h1,
    FGW_LVL2 = 2'h2
  } fgw_level_e;

endpackage : fgw_pkg

/* design/fgw_timeout_counter.sv */
// Time-out counter of the watchdog: counts oscillator ticks up to the selected period.
// Assumes tick is a one-cycle enable at the oscillator rate and clear is synchronous.
`timescale 1ns/1ps
`include "fgw_map.svh"

module fgw_timeout_counter #(
  parameter int BASE_TICKS = `FGW_BASE_TICKS,
  parameter int SEL_W = 3
) (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic tick, // Oscillator tick enable
  input wire logic clear, // Restart the period
  input wire logic [SEL_W-1:0] sel, // Period select, doubling per step
  output logic expire // One-cycle pulse when the period runs out
);

  localparam int CW = $clog2(BASE_TICKS) + (2 ** SEL_W);
  localparam logic [CW-1:0] BASE_L = CW'(BASE_TICKS);
  localparam logic [CW-1:0] ONE_L = CW'(1);

  if (BASE_TICKS < 2) begin : g_bad_base
    $error("BASE_TICKS must be at least 2");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic expire_q;
  logic expire_d;
  logic [CW-1:0] limit;

  assign limit = BASE_L << sel;
  assign expire = expire_q;

  always_comb begin
    cnt_d = cnt_q;
    expire_d = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (tick) begin
      // Compare with >= so a smaller period chosen mid-count still fires
      if (cnt_q >= limit - ONE_L) begin
        cnt_d = '0;
        expire_d = 1'b1;
      end else begin
        cnt_d = cnt_q + ONE_L;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      expire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      expire_q <= expire_d;
    end
  end

endmodule : fgw_timeout_counter

/* design/fgw_watchdog.sv */
// Fuse guarded watchdog timer with its control and reset status registers.
// Assumes fuse levels are stable, chip_rst and restart_instr are one-cycle pulses,
// and the register master follows the one-cycle strobe protocol.
//
// Summary of operation
// - Watchdog counts a 1 MHz tick divided down from the core clock.
// - Restart instruction clears the counter and starts a new period.
// - Counter clears when disabled and on any chip reset.
// - Enabled watchdog reaching the period resets the chip.
// - Two fuses pick safety level 0, 1 or 2 and initial enable.
// - Writing one to enable enables at once, except in the fuse reload and reset pulse cycles, where control writes are dropped.
// - Control bits 7 to 5 read as zero.
// - Change unlock bit clears itself four cycles after being set.
// - Writing enable zero disables only while unlock is open.
// - Enable one turns the watchdog on, permitted zero turns it off.
// - Period select gives 16384 ticks doubling up to 2097152.
// - Level 0 accepts period select on every write.
// - Levels 1 and 2 accept period select only while unlock is open.
// - Level 2 watchdog stays enabled and enable reads one.
// - Level 2 select change follows unlock; written enable value is ignored.
// - Expiry gives a one cycle reset pulse.
// - Expiry sets the reset flag; power-on or writing zero clears it.
`timescale 1ns/1ps
`include "fgw_map.svh"

module fgw_watchdog
  import fgw_pkg::*;
#(
  parameter int OSC_DIV = `FGW_OSC_DIV,
  parameter int BASE_TICKS = `FGW_BASE_TICKS
) (
  input wire logic ref_clk, // Core clock, 200 MHz
  input wire logic rst, // Power-on reset, asynchronous, active high
  input wire logic chip_rst, // Other chip reset sources, one-cycle pulse
  input wire logic restart_instr, // Watchdog restart instruction executed
  input wire logic always_on_fuse, // High when the always-on fuse is programmed
  input wire logic legacy_compat_fuse, // High when the compatibility fuse is programmed
  input wire logic [`FGW_ADDR_W-1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
  output logic wdt_reset_pulse, // Chip reset request on expiry
  output logic wdt_enabled, // Watchdog currently enabled
  output logic [1:0] safety_level // Safety level taken from the fuses
);

  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
  localparam logic [2:0] UNL_ONE = 3'h1;

  if (OSC_DIV < 1) begin : g_bad_div
    $error("OSC_DIV must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  fgw_state_e state_q;
  fgw_state_e state_d;
  fgw_level_e level_q;
  fgw_level_e level_d;
  logic enable_q;
  logic enable_d;
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic [2:0] unl_cnt_q;
  logic [2:0] unl_cnt_d;
  logic flag_q;
  logic flag_d;
  logic pulse_q;
  logic pulse_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;

  logic osc_tick;
  logic expire;
  logic cnt_clear;
  logic window_open;
  logic ctrl_wr;
  logic stat_wr;
  logic w_unlock;
  logic w_enable;
  logic [2:0] w_sel;
  fgw_level_e fuse_level;
  logic [7:0] ctrl_view;
  logic [7:0] stat_view;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  assign window_open = (unl_cnt_q != 3'h0);
  assign ctrl_wr = reg_wr && (reg_addr == `FGW_CTRL_ADDR) && (state_q == FGW_ST_RUN);
  assign stat_wr = reg_wr && (reg_addr == `FGW_STAT_ADDR);
  assign w_unlock = reg_wdata[`FGW_BIT_UNLOCK];
  assign w_enable = reg_wdata[`FGW_BIT_ENABLE];
  assign w_sel = reg_wdata[`FGW_SEL_HI:`FGW_SEL_LO];

  // Always-on wins over compatibility when both fuses are programmed
  always_comb begin
    if (always_on_fuse) begin
      fuse_level = FGW_LVL2;
    end else if (legacy_compat_fuse) begin
      fuse_level = FGW_LVL0;
    end else begin
      fuse_level = FGW_LVL1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator tick divider

  // The oscillator is modelled as a free-running enable from the core clock, so
  // configuration reaches the counter without any crossing hazard
  always_comb begin
    if (div_q == DIV_LAST) begin
      div_d = '0;
    end else begin
      div_d = div_q + DIV_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  assign osc_tick = (div_q == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////////////
  // Time-out counter

  assign cnt_clear = restart_instr || !enable_q || chip_rst || (state_q != FGW_ST_RUN);

  fgw_timeout_counter #(
    .BASE_TICKS(BASE_TICKS),
    .SEL_W(3)
  ) u_counter (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(osc_tick),
    .clear(cnt_clear),
    .sel(sel_q),
    .expire(expire)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: load fuses, run, fire the reset pulse

  always_comb begin
    state_d = state_q;
    pulse_d = 1'b0;
    case (state_q)
      FGW_ST_LOAD: begin
        state_d = FGW_ST_RUN;
      end
      FGW_ST_RUN: begin
        if (expire && enable_q) begin
          state_d = FGW_ST_FIRE;
          pulse_d = 1'b1;
        end
      end
      FGW_ST_FIRE: begin
        // The expiry acts as a chip reset, so the block reloads its fuse state
        state_d = FGW_ST_LOAD;
      end
      default: begin
        state_d = FGW_ST_LOAD;
      end
    endcase
    if (chip_rst) begin
      state_d = FGW_ST_LOAD;
      pulse_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= FGW_ST_LOAD;
      pulse_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulse_q <= pulse_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register

  always_comb begin
    level_d = level_q;
    enable_d = enable_q;
    sel_d = sel_q;
    unl_cnt_d = window_open ? (unl_cnt_q - UNL_ONE) : 3'h0;
    if (state_q == FGW_ST_LOAD) begin
      // Fuses are caught by a clock edge after reset release, never by the reset
      level_d = fuse_level;
      enable_d = (fuse_level == FGW_LVL2);
      sel_d = `FGW_SEL_RESET;
      unl_cnt_d = 3'h0;
    end else if (state_q == FGW_ST_FIRE) begin
      unl_cnt_d = 3'h0;
    end else if (ctrl_wr) begin
      if (w_unlock && w_enable) begin
        unl_cnt_d = `FGW_UNLOCK_CYCLES;
      end
      if (w_enable) begin
        enable_d = 1'b1;
      end else if (window_open && (level_q != FGW_LVL2)) begin
        enable_d = 1'b0;
      end
      if (level_q == FGW_LVL0) begin
        sel_d = w_sel;
      end else if (window_open && !w_unlock) begin
        sel_d = w_sel;
      end
      // Outside the window a zero enable is ignored, and levels 1 and 2 keep the previous select
    end
    if (level_q == FGW_LVL2 && state_q != FGW_ST_LOAD) begin
      enable_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level_q <= FGW_LVL1;
      enable_q <= 1'b0;
      sel_q <= `FGW_SEL_RESET;
      unl_cnt_q <= 3'h0;
    end else begin
      level_q <= level_d;
      enable_q <= enable_d;
      sel_q <= sel_d;
      unl_cnt_q <= unl_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset status flag

  // Only the power-on reset or a zero write clears it, so it survives the reset it reports
  always_comb begin
    flag_d = flag_q;
    if (stat_wr && !reg_wdata[`FGW_BIT_WDFLAG]) begin
      flag_d = 1'b0;
    end
    if (pulse_q) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[`FGW_BIT_UNLOCK] = window_open;
    ctrl_view[`FGW_BIT_ENABLE] = enable_q;
    ctrl_view[`FGW_SEL_HI:`FGW_SEL_LO] = sel_q;
    stat_view = 8'h00;
    stat_view[`FGW_BIT_WDFLAG] = flag_q;
  end

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `FGW_CTRL_ADDR: begin
          rdata_d = ctrl_view;
        end
        `FGW_STAT_ADDR: begin
          rdata_d = stat_view;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = rdata_q;
  assign wdt_reset_pulse = pulse_q;
  assign wdt_enabled = enable_q;
  assign safety_level = level_q;

endmodule : fgw_watchdog

/* dv/fgw_watchdog_chk.sv */
// Port checker for the watchdog: register reads, enable control, expiry pulse.
// Assumes a bind onto fgw_watchdog; one clock domain.
`timescale 1ns/1ps
`include "fgw_map.svh"
module fgw_watchdog_chk (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Power-on reset
  input wire logic chip_rst, // Chip reset pulse
  input wire logic [`FGW_ADDR_W-1:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic wdt_reset_pulse, // Expiry pulse
  input wire logic wdt_enabled, // Enable state
  input wire logic [1:0] safety_level // Safety level
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic busy_q, busy_d, ctl_wr;
  logic [2:0] win_q, win_d;
  ////////////////////////////////////////////////////////////////////////////
  // Control writes are dropped while the fuse defaults reload
  // A write in the chip reset cycle still lands; the reload cycle after it wipes it
  assign ctl_wr = reg_wr && reg_addr == `FGW_CTRL_ADDR && !busy_q && !wdt_reset_pulse;
  always_comb begin
    busy_d = chip_rst || wdt_reset_pulse;
    win_d = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
    if (busy_q || wdt_reset_pulse) begin
      win_d = 3'h0;
    end else if (ctl_wr && reg_wdata[4] && reg_wdata[3]) begin
      win_d = 3'h4;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b1;
      win_q <= 3'h0;
    end else begin
      busy_q <= busy_d;
      win_q <= win_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("reset pulse longer than one cycle");
  a_pulse_cause: assert property (wdt_reset_pulse |-> $past(wdt_enabled))
    else $error("reset pulse while disabled");
  a_level_two_on: assert property (safety_level == 2'h2 |-> wdt_enabled)
    else $error("level 2 watchdog not enabled");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_ctrl_read: assert property (
    $past(reg_rd) && $past(reg_addr) == `FGW_CTRL_ADDR |->
    reg_rdata[7:3] == {3'h0, $past(win_q != 3'h0), $past(wdt_enabled)})
    else $error("control readback wrong");
  a_status_read: assert property (
    $past(reg_rd) && $past(reg_addr) == `FGW_STAT_ADDR |->
    (reg_rdata & 8'hF7) == 8'h00)
    else $error("status spare bits set");
  a_unmapped_read: assert property ($past(reg_rd) && $past(reg_addr) > `FGW_STAT_ADDR |->
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_enable_set: assert property (ctl_wr && reg_wdata[3] |=> wdt_enabled)
    else $error("enable write ignored");
  a_disable_held: assert property (
    ctl_wr && !reg_wdata[3] && win_q == 3'h0 |=>
    wdt_enabled == $past(wdt_enabled))
    else $error("disabled outside window");
  a_disable_open: assert property (
    ctl_wr && !reg_wdata[3] && win_q != 3'h0 &&
    safety_level != 2'h2 |=> !wdt_enabled)
    else $error("disable in window ignored");
  a_reload_dflt: assert property (
    chip_rst || wdt_reset_pulse |->
    ##2 wdt_enabled == (safety_level == 2'h2))
    else $error("fuse default not reloaded");
  c_expiry: cover property (wdt_reset_pulse);
  c_disable: cover property (ctl_wr && !reg_wdata[3] && win_q != 3'h0);
  c_lvl2_wr: cover property (safety_level == 2'h2 && ctl_wr);
endmodule : fgw_watchdog_chk

/* dv/fgw_watchdog_tb.sv */
// Self-checking bench for the watchdog: fuse levels, control window, expiry.
// Assumes the design built with small divider and base count.
`timescale 1ns/1ps
`include "fgw_map.svh"
module fgw_watchdog_tb;
  localparam logic [3:0] CA = `FGW_CTRL_ADDR;
  localparam logic [3:0] SA = `FGW_STAT_ADDR;
  logic ref_clk = 0, rst = 1, chip_rst = 0, restart_instr = 0, ao = 0, lc = 0;
  logic reg_wr = 0, reg_rd = 0, wdt_reset_pulse, wdt_enabled;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [1:0] safety_level;
  int error_cnt = 0, samples_checked = 0, n, pcnt = 0;
  fgw_watchdog #(.OSC_DIV(2), .BASE_TICKS(4)) dut (.ref_clk(ref_clk), .rst(rst),
    .chip_rst(chip_rst), .restart_instr(restart_instr), .always_on_fuse(ao),
    .legacy_compat_fuse(lc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_reset_pulse(wdt_reset_pulse),
    .wdt_enabled(wdt_enabled), .safety_level(safety_level));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wdt_reset_pulse === 1'b1) pcnt++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic do_rst(input logic a, input logic l, input logic [7:0] lvl, input logic [7:0] en);
    @(posedge ref_clk);
    rst <= 1'b1;
    ao <= a;
    lc <= l;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({6'h0, safety_level}, lvl);
    chk({7'h0, wdt_enabled}, en);
  endtask : do_rst
  // Bounded wait; n counts cycles until the expiry pulse
  task automatic wait_pulse;
    n = 0;
    while (wdt_reset_pulse !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 3000) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask : wait_pulse
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // Restart stays high through the level 1 window sequences: the short test
    // period would otherwise expire there and reload the fuse defaults
    restart_instr <= 1'b1;
    do_rst(1'b0, 1'b0, 8'h01, 8'h00);
    rd(CA, 8'h00);
    rd(4'h5, 8'h00);
    wr(CA, 8'h08);
    wr(CA, 8'h00);
    wr(CA, 8'h0B);
    rd(CA, 8'h08);
    wr(CA, 8'h18);
    rd(CA, 8'h18);
    wr(CA, 8'h06);
    repeat (4) @(posedge ref_clk);
    rd(CA, 8'h06);
    wr(CA, 8'h08);
    wr(CA, 8'h18);
    repeat (5) @(posedge ref_clk);
    wr(CA, 8'h00);
    rd(CA, 8'h0E);
    @(posedge ref_clk);
    chip_rst <= 1'b1;
    @(posedge ref_clk);
    chip_rst <= 1'b0;
    rd(CA, 8'h00);
    wr(CA, 8'h08);
    repeat (20) begin
      @(posedge ref_clk);
      restart_instr <= 1'b1;
      @(posedge ref_clk);
      restart_instr <= 1'b0;
      @(posedge ref_clk);
    end
    chk_rng(pcnt, 0, 0);
    wait_pulse();
    chk_rng(n, 1, 12);
    rd(SA, 8'h08);
    wr(SA, 8'h00);
    rd(SA, 8'h00);
    #1 chk({7'h0, wdt_enabled}, 8'h00);
    do_rst(1'b0, 1'b1, 8'h00, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(CA, 8'h08 | s[7:0]);
      wait_pulse();
      chk_rng(n, (8 << s) - 2, (8 << s) + 4);
      repeat (3) @(posedge ref_clk);
    end
    restart_instr <= 1'b1;
    do_rst(1'b1, 1'b1, 8'h02, 8'h01);
    do_rst(1'b1, 1'b0, 8'h02, 8'h01);
    wr(CA, 8'h18);
    wr(CA, 8'h07);
    repeat (3) @(posedge ref_clk);
    rd(CA, 8'h0F);
    end_sim();
  end
endmodule : fgw_watchdog_tb

bind fgw_watchdog fgw_watchdog_chk chk_i (.ref_clk(ref_clk), .rst(rst), .chip_rst(chip_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wdt_reset_pulse(wdt_reset_pulse), .wdt_enabled(wdt_enabled),
  .safety_level(safety_level));
